// file: logic/afecr_pkg.sv
// package of the front-end configuration register bank: offsets, fields, resets, timing
// assumes a 50 MHz system clock and an APB master with 32-bit data
// What this block does
// R1: positive select bits 7:4 route input n to positive side, codes 0 to 11
// R2: negative select bits 3:0 same numbering; 1100 common input; 1101-1111 reserved
// R3: codes 6 to 11 valid only on twelve-channel part; six-channel software avoids them
// R4: after reset positive select is input 0, negative select is input 1
// R5: delay bits 7:5 pick 14,25,64,256,1024,2048,4096 modulator periods before conversion
// R6: amplifier enable bits 4:3: 00 bypass and power down, 01 enabled, rest reserved
// R7: software sets gain to unity whenever it bypasses the amplifier
// R8: gain bits 2:0 give gain two to the code, 1 to 128, reset unity
// R9: gain setting register at 03h, reset 00h: delay, enable, gain
// R10: data-rate register at 04h, reset 14h: chop, clock, mode, filter, rate code
// R11: input select register at 02h, reset 01h: positive upper, negative lower nibble
// R12: conversion mode bit 0 continuous, 1 single-shot
// R13: every field reads back last written value or its reset value
package afecr_pkg;

    // ==========================================================
    // register map
    localparam logic [7:0] OFS_INPUT_SEL  = 8'h08;
    localparam logic [7:0] OFS_GAIN_SET   = 8'h0c;
    localparam logic [7:0] OFS_DATA_RATE  = 8'h10;
    localparam logic [7:0] OFS_FILT_STAT  = 8'h14;
    localparam logic [3:0] IDX_INPUT_SEL  = 4'h2;
    localparam logic [3:0] IDX_GAIN_SET   = 4'h3;
    localparam logic [3:0] IDX_DATA_RATE  = 4'h4;

    // ==========================================================
    // reset values
    localparam logic [7:0] RST_INPUT_SEL  = 8'h01;
    localparam logic [7:0] RST_GAIN_SET   = 8'h00;
    localparam logic [7:0] RST_DATA_RATE  = 8'h14;

    // ==========================================================
    // field positions
    localparam int POS_POS_SEL_LSB = 4;
    localparam int POS_DELAY_LSB = 5;
    localparam int POS_AMPEN_LSB = 3;
    localparam int POS_CHOP      = 7;
    localparam int POS_CLKSRC    = 6;
    localparam int POS_MODE      = 5;
    localparam int POS_FILTER    = 4;

    // ==========================================================
    // codes
    localparam logic [3:0] SEL_COMMON     = 4'hc;
    localparam logic [3:0] SEL_LAST_AIN   = 4'hb;
    localparam logic [3:0] SEL_LAST_SIX   = 4'h5;
    localparam logic [1:0] AMP_BYPASS     = 2'h0;
    localparam logic [1:0] AMP_ENABLED    = 2'h1;
    localparam logic [2:0] DLY_LAST_CODE  = 3'h6;

    // ==========================================================
    // timing: one modulator period at a 4.096 MHz modulator clock is 244 ns, rounded up to 13 cycles of 20 ns
    localparam int MOD_PERIOD_NS  = 244;
    localparam int CLK_PERIOD_NS  = 20;
    localparam int MOD_CYCLES     = (MOD_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DLY_W          = 16;

    typedef enum logic [1:0] {AFECR_IDLE, AFECR_WAIT, AFECR_RUN} afecr_state_t;

endpackage

// file: logic/afecr_delay_rom.sv
// registered lookup of the start delay in modulator periods per delay code
// assumes the caller holds the code stable while it waits one cycle for the value
module afecr_delay_rom (
    // clock and reset
    input  wire logic                           MCLK_I,
    input  wire logic                           RST_B_I,
    // lookup
    input  wire logic [2:0]                     code_i,
    output logic      [afecr_pkg::DLY_W-1:0]    periods_o
);
    logic [afecr_pkg::DLY_W-1:0] periods_d;
    logic [afecr_pkg::DLY_W-1:0] periods_q;

    // R5: period table
    always_comb begin
        unique case (code_i)
            3'h0:    periods_d = 16'h000e;
            3'h1:    periods_d = 16'h0019;
            3'h2:    periods_d = 16'h0040;
            3'h3:    periods_d = 16'h0100;
            3'h4:    periods_d = 16'h0400;
            3'h5:    periods_d = 16'h0800;
            3'h6:    periods_d = 16'h1000;
            // reserved code falls back on the longest wait, the safe side
            default: periods_d = 16'h1000;
        endcase
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            periods_q <= 16'h000e;
        end else begin
            periods_q <= periods_d;
        end
    end

    assign periods_o = periods_q;
endmodule

// file: logic/afecr_regs.sv
// front-end configuration register bank on APB with decoded controls to the analog side
// assumes an APB master on the same clock; the analog front end samples the outputs
//
// The APB interface to the registers was left to the implementer.
module afecr_regs #(
    parameter int TWELVE_CH = 1
) (
    // clock and reset
    input  wire logic        MCLK_I,
    input  wire logic        RST_B_I,
    // apb slave
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    input  wire logic [3:0]  PSTRB_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    // input selection
    output logic      [11:0] POS_INPUT_ONEHOT_O,
    output logic      [11:0] NEG_INPUT_ONEHOT_O,
    output logic             NEG_COMMON_SEL_O,
    output logic             POS_COMMON_SEL_O,
    output logic             SEL_INVALID_O,
    // amplifier
    output logic             AMP_POWER_O,
    output logic             AMP_BYPASS_O,
    output logic      [7:0]  AMP_GAIN_O,
    // data-rate controls
    output logic             CHOP_EN_O,
    output logic             EXT_CLK_SEL_O,
    output logic             SINGLE_SHOT_O,
    output logic             LOW_LAT_FILT_O,
    output logic      [3:0]  OUTPUT_RATE_CODE_O,
    // conversion start after a filter-resetting write
    output logic             FILTER_RESET_O,
    output logic             CONV_START_O
);
    // ==========================================================
    // bus decode
    logic       wr_en;
    logic       rd_en;
    logic       hit_sel;
    logic       hit_gain;
    logic       hit_rate;
    logic       hit_stat;
    logic       mapped;

    assign wr_en    = PSEL_I && PENABLE_I && PWRITE_I && PSTRB_I[0];
    assign rd_en    = PSEL_I && PENABLE_I && !PWRITE_I;
    assign hit_sel  = (PADDR_I == afecr_pkg::OFS_INPUT_SEL);
    assign hit_gain = (PADDR_I == afecr_pkg::OFS_GAIN_SET);
    assign hit_rate = (PADDR_I == afecr_pkg::OFS_DATA_RATE);
    assign hit_stat = (PADDR_I == afecr_pkg::OFS_FILT_STAT);
    assign mapped   = hit_sel || hit_gain || hit_rate || hit_stat;

    assign PREADY_O  = 1'b1;
    // unmapped addresses and writes to the status word answer with an error
    assign PSLVERR_O = PSEL_I && PENABLE_I && (!mapped || (PWRITE_I && hit_stat));

    // ==========================================================
    // register storage
    logic [7:0] input_channel_select_q;
    logic [7:0] input_channel_select_d;
    logic [7:0] gain_setting_q;
    logic [7:0] gain_setting_d;
    logic [7:0] data_rate_config_q;
    logic [7:0] data_rate_config_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic        cfg_write;

    always_comb begin
        input_channel_select_d = input_channel_select_q;
        gain_setting_d         = gain_setting_q;
        data_rate_config_d     = data_rate_config_q;
        cfg_write              = 1'b0;
        // R13: write stores whole byte
        if (wr_en && hit_sel) begin
            input_channel_select_d = PWDATA_I[7:0];
            cfg_write              = 1'b1;
        end
        if (wr_en && hit_gain) begin
            gain_setting_d = PWDATA_I[7:0];
            cfg_write      = 1'b1;
        end
        if (wr_en && hit_rate) begin
            data_rate_config_d = PWDATA_I[7:0];
            cfg_write          = 1'b1;
        end
    end

    // ==========================================================
    // start-delay sequencer
    logic [afecr_pkg::DLY_W-1:0] delay_periods;
    logic [afecr_pkg::DLY_W-1:0] period_cnt_q;
    logic [afecr_pkg::DLY_W-1:0] period_cnt_d;
    logic [7:0]                  mod_cnt_q;
    logic [7:0]                  mod_cnt_d;
    afecr_pkg::afecr_state_t     state_q;
    afecr_pkg::afecr_state_t     state_d;
    logic                        start_d;
    logic                        start_q;
    logic                        freset_q;

    afecr_delay_rom u_delay_rom (
        .MCLK_I    (MCLK_I),
        .RST_B_I   (RST_B_I),
        .code_i    (gain_setting_q[afecr_pkg::POS_DELAY_LSB +: 3]),
        .periods_o (delay_periods)
    );

    // R5: delay before first conversion
    always_comb begin
        state_d      = state_q;
        period_cnt_d = period_cnt_q;
        mod_cnt_d    = mod_cnt_q;
        start_d      = 1'b0;
        unique case (state_q)
            afecr_pkg::AFECR_IDLE: begin
                // one cycle lets the table settle on the newly written code
                if (cfg_write) begin
                    state_d = afecr_pkg::AFECR_WAIT;
                end
            end
            afecr_pkg::AFECR_WAIT: begin
                // the table registers the code a cycle after the write lands,
                // so loading at once would take the delay of the old code
                if (!freset_q) begin
                    period_cnt_d = delay_periods;
                    mod_cnt_d    = 8'(afecr_pkg::MOD_CYCLES - 1);
                    state_d      = afecr_pkg::AFECR_RUN;
                end
            end
            afecr_pkg::AFECR_RUN: begin
                if (mod_cnt_q != 8'h00) begin
                    mod_cnt_d = mod_cnt_q - 8'h01;
                end else if (period_cnt_q > 16'h0001) begin
                    mod_cnt_d    = 8'(afecr_pkg::MOD_CYCLES - 1);
                    period_cnt_d = period_cnt_q - 16'h0001;
                end else begin
                    start_d = 1'b1;
                    state_d = afecr_pkg::AFECR_IDLE;
                end
            end
        endcase
        // a further write restarts the wait from the new settings
        if (cfg_write) begin
            state_d = afecr_pkg::AFECR_WAIT;
            start_d = 1'b0;
        end
    end

    // ==========================================================
    // read mux
    always_comb begin
        prdata_d = prdata_q;
        if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
            prdata_d = 32'h0000_0000;
            // R13: readback of stored value
            if (hit_sel) begin
                prdata_d[7:0] = input_channel_select_q;
            end
            if (hit_gain) begin
                prdata_d[7:0] = gain_setting_q;
            end
            if (hit_rate) begin
                prdata_d[7:0] = data_rate_config_q;
            end
            if (hit_stat) begin
                prdata_d[0] = (state_q != afecr_pkg::AFECR_IDLE);
            end
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            // R4: default input pair
            // R11: input select reset
            input_channel_select_q <= afecr_pkg::RST_INPUT_SEL;
            // R9: gain register reset
            gain_setting_q         <= afecr_pkg::RST_GAIN_SET;
            // R10: data-rate reset
            data_rate_config_q     <= afecr_pkg::RST_DATA_RATE;
            prdata_q               <= 32'h0000_0000;
            state_q                <= afecr_pkg::AFECR_IDLE;
            period_cnt_q           <= 16'h0000;
            mod_cnt_q              <= 8'h00;
            start_q                <= 1'b0;
            freset_q               <= 1'b0;
        end else begin
            input_channel_select_q <= input_channel_select_d;
            gain_setting_q         <= gain_setting_d;
            data_rate_config_q     <= data_rate_config_d;
            prdata_q               <= prdata_d;
            state_q                <= state_d;
            period_cnt_q           <= period_cnt_d;
            mod_cnt_q              <= mod_cnt_d;
            start_q                <= start_d;
            freset_q               <= cfg_write;
        end
    end

    assign PRDATA_O       = rd_en ? prdata_q : 32'h0000_0000;
    assign CONV_START_O   = start_q;
    assign FILTER_RESET_O = freset_q;

    // ==========================================================
    // input decode
    logic [3:0] positive_input_select;
    logic [3:0] negative_input_select;
    assign positive_input_select = input_channel_select_q[afecr_pkg::POS_POS_SEL_LSB +: 4];
    assign negative_input_select = input_channel_select_q[3:0];

    // R1: positive input routing
    // R2: negative input routing
    for (genvar n = 0; n < 12; n++) begin : g_ain
        assign POS_INPUT_ONEHOT_O[n] = (positive_input_select == 4'(n));
        assign NEG_INPUT_ONEHOT_O[n] = (negative_input_select == 4'(n));
    end
    assign POS_COMMON_SEL_O = (positive_input_select == afecr_pkg::SEL_COMMON);
    assign NEG_COMMON_SEL_O = (negative_input_select == afecr_pkg::SEL_COMMON);

    // R3: channel-count check
    logic [3:0] last_ok;
    assign last_ok       = (TWELVE_CH != 0) ? afecr_pkg::SEL_LAST_AIN : afecr_pkg::SEL_LAST_SIX;
    assign SEL_INVALID_O = ((positive_input_select > last_ok)
                            && (positive_input_select != afecr_pkg::SEL_COMMON))
                        || ((negative_input_select > last_ok)
                            && (negative_input_select != afecr_pkg::SEL_COMMON));

    // ==========================================================
    // amplifier decode
    logic [1:0] amp_en;
    logic [2:0] gain;
    assign amp_en = gain_setting_q[afecr_pkg::POS_AMPEN_LSB +: 2];
    assign gain   = gain_setting_q[2:0];

    // R6: enable or bypass; reserved codes also bypass
    assign AMP_POWER_O  = (amp_en == afecr_pkg::AMP_ENABLED);
    assign AMP_BYPASS_O = (amp_en != afecr_pkg::AMP_ENABLED);
    // R7: bypass forces unity, covering software that forgets
    // R8: gain power of two
    assign AMP_GAIN_O   = AMP_BYPASS_O ? 8'h01 : (8'h01 << gain);

    // R10: data-rate fields
    assign CHOP_EN_O          = data_rate_config_q[afecr_pkg::POS_CHOP];
    assign EXT_CLK_SEL_O      = data_rate_config_q[afecr_pkg::POS_CLKSRC];
    // R12: mode bit
    assign SINGLE_SHOT_O      = data_rate_config_q[afecr_pkg::POS_MODE];
    assign LOW_LAT_FILT_O     = data_rate_config_q[afecr_pkg::POS_FILTER];
    assign OUTPUT_RATE_CODE_O = data_rate_config_q[3:0];
endmodule

// file: sim/afecr_regs_monitor.sv
// checker of the front-end register bank: apb answers and decoded controls
// assumes it is bound into afecr_regs and sees only its ports
module afecr_regs_monitor #(
    parameter int TWELVE_CH = 1
) (
    // clock, reset, apb
    input wire logic        MCLK_I,
    input wire logic        RST_B_I,
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [7:0]  PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [3:0]  PSTRB_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic        PREADY_O,
    input wire logic        PSLVERR_O,
    // decoded controls
    input wire logic [11:0] POS_INPUT_ONEHOT_O,
    input wire logic [11:0] NEG_INPUT_ONEHOT_O,
    input wire logic        NEG_COMMON_SEL_O,
    input wire logic        AMP_POWER_O,
    input wire logic        AMP_BYPASS_O,
    input wire logic [7:0]  AMP_GAIN_O,
    input wire logic        CHOP_EN_O,
    input wire logic        EXT_CLK_SEL_O,
    input wire logic        SINGLE_SHOT_O,
    input wire logic        LOW_LAT_FILT_O,
    input wire logic [3:0]  OUTPUT_RATE_CODE_O,
    input wire logic        FILTER_RESET_O,
    input wire logic        CONV_START_O
);
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!RST_B_I);
    logic       acc;
    logic       wr;
    logic [7:0] rate;
    assign acc  = PSEL_I && PENABLE_I && PREADY_O;
    assign wr   = acc && PWRITE_I && PSTRB_I[0];
    assign rate = {CHOP_EN_O, EXT_CLK_SEL_O, SINGLE_SHOT_O, LOW_LAT_FILT_O, OUTPUT_RATE_CODE_O};
    // ==========================================================
    // assertions
    ready_zero_wait_a: assert property (PSEL_I |-> PREADY_O)
        else $error("pready low in a transfer");
    unmapped_err_a: assert property (acc && PADDR_I > 8'h14
        |-> PSLVERR_O && PRDATA_O == 32'h0) else $error("unmapped access not refused");
    pos_decode_a: assert property (wr && PADDR_I == afecr_pkg::OFS_INPUT_SEL
        && PWDATA_I[7:4] <= (TWELVE_CH ? 4'hb : 4'h5)
        |=> POS_INPUT_ONEHOT_O == 12'h1 << $past(PWDATA_I[7:4])) else $error("positive decode");
    neg_common_a: assert property (wr && PADDR_I == afecr_pkg::OFS_INPUT_SEL
        && PWDATA_I[3:0] == 4'hc |=> NEG_COMMON_SEL_O && NEG_INPUT_ONEHOT_O == 12'h0)
        else $error("common input decode");
    gain_decode_a: assert property (wr && PADDR_I == afecr_pkg::OFS_GAIN_SET
        && PWDATA_I[4:3] == 2'h1 |=> AMP_POWER_O && AMP_GAIN_O == 8'h1 << $past(PWDATA_I[2:0]))
        else $error("gain decode");
    bypass_unity_a: assert property (AMP_BYPASS_O |-> !AMP_POWER_O && AMP_GAIN_O == 8'h01)
        else $error("bypass not unity");
    rate_fields_a: assert property (wr && PADDR_I == afecr_pkg::OFS_DATA_RATE
        |=> rate == $past(PWDATA_I[7:0])) else $error("data-rate fields");
    reset_values_a: assert property (disable iff (1'b0) !RST_B_I |=> rate == 8'h14
        && POS_INPUT_ONEHOT_O == 12'h1 && NEG_INPUT_ONEHOT_O == 12'h2 && AMP_BYPASS_O)
        else $error("reset values");
    filter_pulse_a: assert property (wr && PADDR_I inside {8'h08, 8'h0c, 8'h10}
        |=> FILTER_RESET_O) else $error("no filter reset pulse");
    cover property (CONV_START_O);
    cover property (wr && PADDR_I == afecr_pkg::OFS_GAIN_SET);
    cover property (PSLVERR_O);
endmodule

bind afecr_regs afecr_regs_monitor #(.TWELVE_CH(TWELVE_CH)) afecr_regs_monitor_inst (
    .MCLK_I(MCLK_I), .RST_B_I(RST_B_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I),
    .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
    .POS_INPUT_ONEHOT_O(POS_INPUT_ONEHOT_O), .NEG_INPUT_ONEHOT_O(NEG_INPUT_ONEHOT_O),
    .NEG_COMMON_SEL_O(NEG_COMMON_SEL_O), .AMP_POWER_O(AMP_POWER_O),
    .AMP_BYPASS_O(AMP_BYPASS_O), .AMP_GAIN_O(AMP_GAIN_O), .CHOP_EN_O(CHOP_EN_O),
    .EXT_CLK_SEL_O(EXT_CLK_SEL_O), .SINGLE_SHOT_O(SINGLE_SHOT_O),
    .LOW_LAT_FILT_O(LOW_LAT_FILT_O), .OUTPUT_RATE_CODE_O(OUTPUT_RATE_CODE_O),
    .FILTER_RESET_O(FILTER_RESET_O), .CONV_START_O(CONV_START_O)
);

// file: sim/afecr_regs_tb.sv
// bench of the register bank: apb traffic, refusals, decoded controls, start delay
// assumes the default twelve-channel build
module afecr_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [31:0] rd; logic err;} afecr_exp_t;
    logic        clk = 1'b0, rst_b = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0]  paddr = 8'h00, gain, shadow [2:4];
    logic [31:0] pwdata = 32'h0, prdata, v;
    logic [3:0]  pstrb = 4'h0;
    logic        pready, pslverr, neg_com, pos_com, sel_inv, amp_pw, filt_rst, conv;
    logic [11:0] pos_oh, neg_oh;
    wire  [7:0]  rate_f;
    int          num_errors = 0, n_compared = 0, t;
    int          per [4] = '{14, 25, 64, 256};
    afecr_exp_t  exp_q [$];
    afecr_exp_t  got;

    afecr_regs afecr_regs_inst (
        .MCLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .POS_INPUT_ONEHOT_O(pos_oh),
        .NEG_INPUT_ONEHOT_O(neg_oh), .NEG_COMMON_SEL_O(neg_com), .POS_COMMON_SEL_O(pos_com),
        .SEL_INVALID_O(sel_inv), .AMP_POWER_O(amp_pw), .AMP_BYPASS_O(), .AMP_GAIN_O(gain),
        .CHOP_EN_O(rate_f[7]), .EXT_CLK_SEL_O(rate_f[6]), .SINGLE_SHOT_O(rate_f[5]),
        .LOW_LAT_FILT_O(rate_f[4]), .OUTPUT_RATE_CODE_O(rate_f[3:0]),
        .FILTER_RESET_O(filt_rst), .CONV_START_O(conv)
    );

    always #10 clk = ~clk;

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wrap_up();
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // one transfer; an idle cycle separates calls so no signal is driven twice in a step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        afecr_exp_t e;
        int         n;
        e.err = a > 8'h14 || a < 8'h08 || a[1:0] != 2'b00 || (w && a == 8'h14);
        e.rd  = (!e.err && a != 8'h14) ? {24'h0, shadow[a[4:2]]} : 32'h0;
        if (w && s[0] && !e.err)
            shadow[a[4:2]] = d[7:0];
        exp_q.push_back(e);
        @(posedge clk);
        psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d; pstrb <= s;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin num_errors++; wrap_up(); end
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic fields();
        logic [3:0] p, n;
        p = shadow[2][7:4];
        n = shadow[2][3:0];
        @(negedge clk);
        chk("pos_sel", p < 12 ? 12'h1 << p : 12'h0, pos_oh);
        chk("neg_sel", n < 12 ? 12'h1 << n : 12'h0, neg_oh);
        chk("common", {n == 4'hc, p == 4'hc}, {neg_com, pos_com});
        chk("invalid", p > 12 || n > 12, sel_inv);
        chk("amp_pw", shadow[3][4:3] == 2'h1, amp_pw);
        chk("gain", shadow[3][4:3] == 2'h1 ? 8'h1 << shadow[3][2:0] : 8'h1, gain);
        chk("rate", shadow[4], rate_f);
    endtask

    task automatic reset_and_check();
        shadow = '{8'h01, 8'h00, 8'h14};
        for (int k = 2; k < 5; k++) apb(1'b0, 8'(4 * k), 32'h0, 4'h0);
        fields();
    endtask

    // completion watcher: every finished transfer takes the oldest note
    always @(posedge clk) begin
        if (psel && pen && pready === 1'b1) begin
            got = exp_q.pop_front();
            if (!pwr) chk("prdata", got.rd, prdata);
            chk("pslverr", got.err, pslverr);
        end
    end

    initial begin
        void'($urandom(32'h3769efc0));
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        reset_and_check();
        for (int i = 0; i < 15; i++) begin
            v = $urandom;
            if (i % 3 == 0) v[7:0] = {4'(v[7:4] % 13), 4'(v[3:0] % 13)};
            // bypass needs unity gain, so random gain only goes with the enabled code
            if (i % 3 == 1) begin v[4] = 1'b0; if (!v[3]) v[2:0] = 3'h0; end
            apb(1'b1, 8'(8 + 4 * (i % 3)), v, 4'h1);
            apb(1'b0, 8'(8 + 4 * (i % 3)), 32'h0, 4'h0);
            fields();
        end
        // refusals: lane off, unmapped, read-only status; then a reserved positive code with common negative, stored and flagged invalid
        apb(1'b1, afecr_pkg::OFS_GAIN_SET, 32'h0b, 4'h0);
        apb(1'b0, afecr_pkg::OFS_GAIN_SET, 32'h0, 4'h0);
        apb(1'b0, 8'h20, 32'h0, 4'h0);
        apb(1'b1, afecr_pkg::OFS_FILT_STAT, 32'h1, 4'h1);
        apb(1'b1, afecr_pkg::OFS_INPUT_SEL, 32'hdc, 4'h1);
        fields();
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, afecr_pkg::OFS_GAIN_SET, 32'(c) << 5, 4'h1);
            t = 0;
            while (conv !== 1'b1 && t < 4000) begin @(negedge clk); t++; end
            chk("delay", 1, t > per[c] * 13 - 5 && t < per[c] * 13 + 5);
        end
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        reset_and_check();
        wrap_up();
    end
endmodule
